// file: hw/flash_rww_pkg.sv
// constants and types for the flash self-program access controller
package flash_rww_pkg;

    // ==========================================================
    // flash geometry (word addresses)
    localparam int          FA_W       = 15;
    localparam logic [14:0] NO_READ_WHILE_WRITE_SECTION_START = 15'h7000;
    localparam logic [14:0] BOOT_ST_00 = 15'h7000;
    localparam logic [14:0] BOOT_ST_01 = 15'h7800;
    localparam logic [14:0] BOOT_ST_10 = 15'h7c00;
    localparam logic [14:0] BOOT_ST_11 = 15'h7e00;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL  = 8'h00;
    localparam logic [7:0]  ADDR_LOCK  = 8'h04;
    localparam logic [7:0]  ADDR_LDATA = 8'h08;
    localparam logic [7:0]  ADDR_STAT  = 8'h0c;
    localparam logic [7:0]  ADDR_MASK  = 8'h10;

    // control register fields
    localparam int          CTRL_OP_LSB = 0;
    localparam int          CTRL_RWWB   = 6;
    localparam int          CTRL_BUSY   = 7;

    // lock bit positions (0 = programmed)
    localparam int          LK_APP_LOW   = 0;
    localparam int          LK_APP_HIGH  = 1;
    localparam int          LK_BOOT_LOW  = 2;
    localparam int          LK_BOOT_HIGH = 3;
    localparam logic [3:0]  LOCK_RESET   = 4'hf;

    // status / mask bits
    localparam int          NST        = 3;
    localparam int          ST_DONE    = 0;
    localparam int          ST_REFUSE  = 1;
    localparam int          ST_LPMDENY = 2;
    localparam logic [2:0]  STAT_RESET = 3'h0;

    typedef enum logic [1:0] {
        OP_ERASE   = 2'b00,
        OP_WRITE   = 2'b01,
        OP_LOCK    = 2'b10,
        OP_RWW_CLR = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_RWW  = 2'b01,
        S_NO_READ_WHILE_WRITE_SECTION = 2'b10
    } state_t;

endpackage

// file: hw/flash_section_map.sv
// classifies a flash word address into boot / no-read-while-write sections
`timescale 1ns/10ps
module flash_section_map
    import flash_rww_pkg::*;
(
    input  wire logic [14:0] addr,
    input  wire logic [1:0]  boot_size,
    output logic             in_boot,
    output logic             in_no_read_while_write_section
);
    logic [14:0] boot_start;

    always_comb begin
        if (boot_size == 2'b00) begin
            boot_start = BOOT_ST_00;
        end else if (boot_size == 2'b01) begin
            boot_start = BOOT_ST_01;
        end else if (boot_size == 2'b10) begin
            boot_start = BOOT_ST_10;
        end else begin
            boot_start = BOOT_ST_11;
        end
    end

    // largest boot area starts at the no_read_while_write_section limit, so boot is always no_read_while_write_section
    assign in_boot = (addr >= boot_start);
    assign in_no_read_while_write_section = (addr >= NO_READ_WHILE_WRITE_SECTION_START);
endmodule

// file: hw/flash_rww_ctrl.sv
// self-program access control, lock bits and read-while-write stall logic
//
// Summary of operation
// [RULE_01] store instruction from application section ignored
// [RULE_02] programming starts only from boot loader
// [RULE_03] boot loader may target any flash address
// [RULE_04] two sections split by boot size fuses
// [RULE_05] app uses lock set 0, boot set 1
// [RULE_06] two lock sets, set independently
// [RULE_07] halt depends on target address section
// [RULE_08] rww target: cpu keeps running from no_read_while_write_section
// [RULE_09] no_read_while_write_section target: cpu halted whole operation
// [RULE_10] boot section always inside no_read_while_write_section region
// [RULE_11] busy flag reads one while rww blocked
// [RULE_12] software clears busy before reading rww
// [RULE_13] software never reads rww during programming
// [RULE_14] software masks or moves interrupts meanwhile
// [RULE_15] lock pair decodes write and load blocks
// [RULE_16] protected section execution disables interrupts
// [RULE_17] lock bits return high only on chip erase; the code also restores them to LOCK_RESET on RST
// [RULE_18] rww programming start sets sticky busy flag
`timescale 1ns/10ps
module flash_rww_ctrl
    import flash_rww_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // fuses and cpu side
    input  wire logic [1:0]  BOOT_SIZE,
    input  wire logic        VEC_IN_BOOT,
    input  wire logic        SPM_REQ,
    input  wire logic [14:0] SPM_PC,
    input  wire logic [14:0] SPM_Z,
    input  wire logic        LPM_REQ,
    input  wire logic [14:0] LPM_PC,
    input  wire logic [14:0] LPM_ADDR,
    input  wire logic [14:0] EXEC_PC,
    // external programmer
    input  wire logic        EXT_LOCK_WE,
    input  wire logic [3:0]  EXT_LOCK_VAL,
    input  wire logic        CHIP_ERASE,
    // flash array
    input  wire logic        FL_DONE,
    output logic             FL_START,
    output logic             FL_OP,
    output logic      [14:0] FL_ADDR,
    // stall and status
    output logic             CPU_HALT,
    output logic             RWW_BLOCK,
    output logic             LPM_DENY,
    output logic             IRQ_BLOCK,
    output logic             IRQ
);

    // ==========================================================
    // section decoding
    logic spm_pc_boot;
    logic tgt_boot;
    logic tgt_no_read_while_write_section;
    logic lpm_pc_boot;
    logic lpm_tgt_boot;
    logic exec_boot;

    flash_section_map u_map_spm_pc (
        .addr      (SPM_PC),
        .boot_size (BOOT_SIZE),
        .in_boot   (spm_pc_boot),
        .in_no_read_while_write_section   ()
    );

    flash_section_map u_map_spm_z (
        .addr      (SPM_Z),
        .boot_size (BOOT_SIZE),
        .in_boot   (tgt_boot),
        .in_no_read_while_write_section   (tgt_no_read_while_write_section)
    );

    flash_section_map u_map_lpm_pc (
        .addr      (LPM_PC),
        .boot_size (BOOT_SIZE),
        .in_boot   (lpm_pc_boot),
        .in_no_read_while_write_section   ()
    );

    flash_section_map u_map_lpm_tgt (
        .addr      (LPM_ADDR),
        .boot_size (BOOT_SIZE),
        .in_boot   (lpm_tgt_boot),
        .in_no_read_while_write_section   ()
    );

    flash_section_map u_map_exec (
        .addr      (EXEC_PC),
        .boot_size (BOOT_SIZE),
        .in_boot   (exec_boot),
        .in_no_read_while_write_section   ()
    );

    // ==========================================================
    // registers and state
    state_t          state_q;
    state_t          state_d;
    logic [1:0]      op_q;
    logic [3:0]      lock_q;
    logic [3:0]      ldata_q;
    logic [NST-1:0]  stat_q;
    logic [NST-1:0]  mask_q;
    logic            rww_busy_q;
    logic            pready_q;
    logic            pslverr_q;
    logic [31:0]     prdata_q;
    logic            fl_start_q;
    logic            fl_op_q;
    logic [14:0]     fl_addr_q;
    logic            halt_q;
    logic            lpm_deny_q;
    logic            irq_block_q;
    logic            irq_q;

    // ==========================================================
    // lock decoding
    logic app_wr_blk;
    logic boot_wr_blk;
    logic app_ld_blk;
    logic boot_ld_blk;
    logic tgt_wr_blk;

    // low bit programmed blocks writes, high bit blocks loads
    assign app_wr_blk  = ~lock_q[LK_APP_LOW];   // [RULE_05] [RULE_15]
    assign boot_wr_blk = ~lock_q[LK_BOOT_LOW];  // [RULE_05] [RULE_15]
    assign app_ld_blk  = ~lock_q[LK_APP_HIGH];  // [RULE_15]
    assign boot_ld_blk = ~lock_q[LK_BOOT_HIGH]; // [RULE_15]
    // any address is reachable; only locks of its section refuse
    assign tgt_wr_blk  = tgt_boot ? boot_wr_blk : app_wr_blk; // [RULE_03] [RULE_04]

    // ==========================================================
    // store instruction acceptance
    logic spm_idle;
    logic spm_from_boot;
    logic spm_prog;
    logic spm_ok;
    logic spm_refuse;
    logic spm_lock;
    logic spm_rww_clr;

    assign spm_idle      = SPM_REQ && (state_q == S_IDLE);
    // application-section requests start nothing and only set the ST_REFUSE status bit
    assign spm_from_boot = spm_idle && spm_pc_boot; // [RULE_01] [RULE_02]
    assign spm_prog      = (op_q == OP_ERASE) || (op_q == OP_WRITE);
    assign spm_ok        = spm_from_boot && spm_prog && !tgt_wr_blk;
    assign spm_lock      = spm_from_boot && (op_q == OP_LOCK);
    assign spm_rww_clr   = spm_from_boot && (op_q == OP_RWW_CLR);
    assign spm_refuse    = SPM_REQ && !(spm_ok || spm_lock || spm_rww_clr);

    // ==========================================================
    // programming state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (spm_ok) begin
                    // stall choice follows the target, not the caller
                    state_d = tgt_no_read_while_write_section ? S_NO_READ_WHILE_WRITE_SECTION : S_RWW; // [RULE_07]
                end
            end
            S_RWW, S_NO_READ_WHILE_WRITE_SECTION: begin
                if (FL_DONE) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // flash array command, one-cycle start pulse
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            fl_start_q <= 1'b0;
            fl_op_q    <= 1'b0;
            fl_addr_q  <= '0;
        end else begin
            fl_start_q <= spm_ok; // [RULE_02]
            if (spm_ok) begin
                fl_op_q   <= (op_q == OP_WRITE);
                fl_addr_q <= SPM_Z; // [RULE_03]
            end
        end
    end

    // cpu halted for the whole no_read_while_write_section operation; rww keeps it running
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= (state_d == S_NO_READ_WHILE_WRITE_SECTION); // [RULE_08] [RULE_09] [RULE_10]
        end
    end

    // sticky busy: set by rww start, cleared by a boot clear request
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rww_busy_q <= 1'b0;
        end else if (spm_ok && !tgt_no_read_while_write_section) begin
            rww_busy_q <= 1'b1; // [RULE_18]
        end else if (spm_rww_clr) begin
            rww_busy_q <= 1'b0; // [RULE_12]
        end
    end

    // ==========================================================
    // lock bits: program only toward zero, chip erase restores
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            lock_q <= LOCK_RESET;
        end else if (CHIP_ERASE) begin
            lock_q <= LOCK_RESET; // [RULE_17]
        end else begin
            // each source only programs zeros; neither disturbs the other
            lock_q <= lock_q & (EXT_LOCK_WE ? EXT_LOCK_VAL : LOCK_RESET) &
                      (spm_lock ? ldata_q : LOCK_RESET); // [RULE_06] [RULE_17]
        end
    end

    // ==========================================================
    // load and interrupt gating
    logic lpm_cross_blk;
    logic irq_blk_d;

    // a load is refused only when it crosses into a load-locked section
    assign lpm_cross_blk = LPM_REQ &&
        ((lpm_pc_boot && !lpm_tgt_boot && app_ld_blk) ||
         (!lpm_pc_boot && lpm_tgt_boot && boot_ld_blk)); // [RULE_15]

    assign irq_blk_d =
        (!exec_boot && app_ld_blk && VEC_IN_BOOT) ||
        (exec_boot && boot_ld_blk && !VEC_IN_BOOT); // [RULE_16]

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            lpm_deny_q  <= 1'b0;
            irq_block_q <= 1'b0;
        end else begin
            lpm_deny_q  <= lpm_cross_blk;
            irq_block_q <= irq_blk_d;
        end
    end

    // ==========================================================
    // apb slave: ready one cycle into the access phase
    logic        acc;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic [31:0] rd_data;

    assign acc   = PSEL && PENABLE && !pready_q;
    assign wr_en = PSEL && PENABLE && pready_q && PWRITE && addr_ok;
    assign rd_en = acc && !PWRITE;

    always_comb begin
        rd_data = '0;
        addr_ok = 1'b1;
        if (PADDR == ADDR_CTRL) begin
            rd_data[CTRL_OP_LSB +: 2] = op_q;
            rd_data[CTRL_RWWB]        = rww_busy_q; // [RULE_11]
            rd_data[CTRL_BUSY]        = (state_q != S_IDLE);
        end else if (PADDR == ADDR_LOCK) begin
            rd_data[3:0] = lock_q;
        end else if (PADDR == ADDR_LDATA) begin
            rd_data[3:0] = ldata_q;
        end else if (PADDR == ADDR_STAT) begin
            rd_data[NST-1:0] = stat_q;
        end else if (PADDR == ADDR_MASK) begin
            rd_data[NST-1:0] = mask_q;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc && !addr_ok;
            if (rd_en) begin
                prdata_q <= rd_data;
            end
        end
    end

    // software registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            op_q    <= OP_ERASE;
            ldata_q <= LOCK_RESET;
            mask_q  <= STAT_RESET;
        end else if (wr_en) begin
            if (PADDR == ADDR_CTRL) begin
                op_q <= PWDATA[CTRL_OP_LSB +: 2];
            end else if (PADDR == ADDR_LDATA) begin
                ldata_q <= PWDATA[3:0];
            end else if (PADDR == ADDR_MASK) begin
                mask_q <= PWDATA[NST-1:0];
            end
        end
    end

    // ==========================================================
    // sticky events; a new event beats a same-cycle clear
    logic [NST-1:0] ev;
    logic [NST-1:0] w1c;

    assign ev[ST_DONE]    = (state_q != S_IDLE) && FL_DONE;
    assign ev[ST_REFUSE]  = spm_refuse; // [RULE_01]
    assign ev[ST_LPMDENY] = lpm_cross_blk;
    assign w1c = (wr_en && (PADDR == ADDR_STAT)) ? PWDATA[NST-1:0] : '0;

    generate
        for (genvar i = 0; i < NST; i++) begin : g_stat
            always_ff @(posedge CLK_SYS or posedge RST) begin
                if (RST) begin
                    stat_q[i] <= 1'b0;
                end else if (ev[i]) begin
                    stat_q[i] <= 1'b1;
                end else if (w1c[i]) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((stat_q & ~w1c) | ev) & mask_q);
        end
    end

    // ==========================================================
    // outputs
    assign PRDATA    = prdata_q;
    assign PREADY    = pready_q;
    assign PSLVERR   = pslverr_q;
    assign FL_START  = fl_start_q;
    assign FL_OP     = fl_op_q;
    assign FL_ADDR   = fl_addr_q;
    assign CPU_HALT  = halt_q;
    assign RWW_BLOCK = rww_busy_q; // [RULE_11]
    assign LPM_DENY  = lpm_deny_q;
    assign IRQ_BLOCK = irq_block_q;
    assign IRQ       = irq_q;

endmodule

// file: verification/flash_rww_monitor.sv
// concurrent checks on the flash self-program controller ports
`timescale 1ns/10ps
module flash_rww_monitor (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        SPM_REQ,
    input wire logic [14:0] SPM_PC,
    input wire logic        LPM_REQ,
    input wire logic        FL_DONE,
    input wire logic        FL_START,
    input wire logic [14:0] FL_ADDR,
    input wire logic        CPU_HALT,
    input wire logic        RWW_BLOCK,
    input wire logic        LPM_DENY
);
    // ==========================================================
    // properties
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_app_ignored: assert property (
        SPM_REQ && SPM_PC < 15'h7000 |=> !FL_START && !$rose(CPU_HALT))
        else $error("store from application started flash");
    a_start_cause: assert property (
        FL_START |-> $past(SPM_REQ) && $past(SPM_PC) >= 15'h7000)
        else $error("flash start without store from boot");
    a_start_pulse: assert property (FL_START |=> !FL_START)
        else $error("flash start longer than one cycle");
    a_no_read_while_write_section_halts: assert property (
        FL_START && FL_ADDR >= 15'h7000 |-> CPU_HALT)
        else $error("no_read_while_write_section target did not halt cpu");
    a_rww_runs: assert property (
        FL_START && FL_ADDR < 15'h7000 |-> !CPU_HALT && RWW_BLOCK)
        else $error("rww target halted cpu or left busy clear");
    a_halt_held: assert property (CPU_HALT && !FL_DONE |=> CPU_HALT)
        else $error("halt dropped before flash done");
    a_halt_target: assert property (CPU_HALT |-> FL_ADDR >= 15'h7000)
        else $error("halt while target lies in rww section");
    a_busy_sticky: assert property (
        RWW_BLOCK && !SPM_REQ |=> RWW_BLOCK)
        else $error("busy flag cleared without store");
    a_deny_cause: assert property (LPM_DENY |-> $past(LPM_REQ))
        else $error("load denial without load request");
endmodule

bind flash_rww_ctrl flash_rww_monitor u_mon (
    .CLK_SYS  (CLK_SYS),
    .RST      (RST),
    .SPM_REQ  (SPM_REQ),
    .SPM_PC   (SPM_PC),
    .LPM_REQ  (LPM_REQ),
    .FL_DONE  (FL_DONE),
    .FL_START (FL_START),
    .FL_ADDR  (FL_ADDR),
    .CPU_HALT (CPU_HALT),
    .RWW_BLOCK(RWW_BLOCK),
    .LPM_DENY (LPM_DENY)
);

// file: verification/cpu_flash_model.sv
// behavioural cpu and flash array on the far side of the controller
`timescale 1ns/10ps
module cpu_flash_model
    import flash_rww_pkg::*;
#(
    parameter int DONE_LAT = 6
)(
    input  wire logic        clk,
    input  wire logic        fl_start,
    input  wire logic        rww_block,
    output logic             spm_req,
    output logic      [14:0] spm_pc,
    output logic      [14:0] spm_z,
    output logic             lpm_req,
    output logic      [14:0] lpm_pc,
    output logic      [14:0] lpm_addr,
    output logic      [14:0] exec_pc,
    output logic             fl_done
);
    int cnt = 0;

    initial begin
        spm_req = 1'b0;
        spm_pc = 15'h0;
        spm_z = 15'h0;
        lpm_req = 1'b0;
        lpm_pc = 15'h0;
        lpm_addr = 15'h0;
        exec_pc = 15'h0;
    end

    // ==========================================================
    // flash array: done pulse a fixed time after each start
    always @(posedge clk) begin
        if (fl_start)
            cnt <= DONE_LAT;
        else if (cnt > 0)
            cnt <= cnt - 1;
        fl_done <= (cnt == 1);
    end

    // ==========================================================
    // cpu instructions; stale address lines are inverted on release
    task automatic store_program_memory_instr(input logic [14:0] pc, input logic [14:0] z);
        @(posedge clk);
        exec_pc <= pc;
        spm_pc <= pc;
        spm_z <= z;
        spm_req <= 1'b1;
        @(posedge clk);
        spm_req <= 1'b0;
        spm_z <= ~z;
    endtask

    task automatic lpm(input logic [14:0] pc, input logic [14:0] a);
        while (rww_block && a < NO_READ_WHILE_WRITE_SECTION_START)
            @(posedge clk);
        @(posedge clk);
        exec_pc <= pc;
        lpm_pc <= pc;
        lpm_addr <= a;
        lpm_req <= 1'b1;
        @(posedge clk);
        lpm_req <= 1'b0;
        lpm_addr <= ~a;
    endtask
endmodule

// file: verification/flash_rww_ctrl_tb.sv
// self-checking testbench for the flash self-program controller
`timescale 1ns/10ps
module flash_rww_ctrl_tb
    import flash_rww_pkg::*;
();
    localparam int DONE_LAT = 6;
    typedef struct packed {
        logic [1:0]  bsz;
        logic [14:0] pc;
        logic [14:0] z;
        logic [1:0]  op;
        logic [2:0]  res; // start, halt, busy
    } row_t;
    row_t rows [6] = '{
        '{2'b00, 15'h0100, 15'h0200, 2'b01, 3'b000},
        '{2'b00, 15'h7000, 15'h0100, 2'b01, 3'b101},
        '{2'b00, 15'h7000, 15'h7100, 2'b00, 3'b110},
        '{2'b11, 15'h7100, 15'h0100, 2'b00, 3'b000},
        '{2'b11, 15'h7e00, 15'h7e00, 2'b01, 3'b110},
        '{2'b10, 15'h7c00, 15'h6fff, 2'b00, 3'b101}};
    logic        clk = 1'b0, rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, fl_start, fl_op, fl_done;
    logic [1:0]  boot_size = 2'b00;
    logic        vec_in_boot = 1'b0, ext_we = 1'b0, chip_erase = 1'b0;
    logic [3:0]  ext_val = 4'hf;
    logic        spm_req, lpm_req, cpu_halt, rww_block;
    logic        lpm_deny, irq_block, irq;
    logic [14:0] spm_pc, spm_z, lpm_pc, lpm_addr, exec_pc, fl_addr;
    int          n_errors = 0, checks = 0;

    always #2 clk = ~clk;

    flash_rww_ctrl dut (
        .CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BOOT_SIZE(boot_size), .VEC_IN_BOOT(vec_in_boot),
        .SPM_REQ(spm_req), .SPM_PC(spm_pc), .SPM_Z(spm_z),
        .LPM_REQ(lpm_req), .LPM_PC(lpm_pc), .LPM_ADDR(lpm_addr),
        .EXEC_PC(exec_pc), .EXT_LOCK_WE(ext_we),
        .EXT_LOCK_VAL(ext_val), .CHIP_ERASE(chip_erase),
        .FL_DONE(fl_done), .FL_START(fl_start), .FL_OP(fl_op),
        .FL_ADDR(fl_addr), .CPU_HALT(cpu_halt), .RWW_BLOCK(rww_block),
        .LPM_DENY(lpm_deny), .IRQ_BLOCK(irq_block), .IRQ(irq));

    cpu_flash_model #(.DONE_LAT(DONE_LAT)) u_cpu (
        .clk(clk), .fl_start(fl_start), .rww_block(rww_block),
        .spm_req(spm_req), .spm_pc(spm_pc), .spm_z(spm_z),
        .lpm_req(lpm_req), .lpm_pc(lpm_pc), .lpm_addr(lpm_addr),
        .exec_pc(exec_pc), .fl_done(fl_done));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string s, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(s, r, exp);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end

    // ==========================================================
    // table of store requests, then hand-written cases
    initial begin
        logic [31:0] d;
        logic        e;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            boot_size <= rows[i].bsz;
            wr(ADDR_CTRL, {30'h0, rows[i].op});
            u_cpu.store_program_memory_instr(rows[i].pc, rows[i].z);
            @(negedge clk);
            check("start", fl_start, rows[i].res[2]);
            check("halt", cpu_halt, rows[i].res[1]);
            check("busy", rww_block, rows[i].res[0]);
            if (rows[i].res[2]) begin
                check("addr", fl_addr, rows[i].z);
                check("op", fl_op, rows[i].op[0]);
            end
            repeat (DONE_LAT + 4) @(posedge clk);
            check("halt_end", cpu_halt, 1'b0);
            rd_chk("status", ADDR_STAT,
                   {30'h0, ~rows[i].res[2], rows[i].res[2]});
            check("irq_masked", irq, 1'b0);
            if (rows[i].res[0]) begin
                rd_chk("busy_bit", ADDR_CTRL,
                       {24'h0, 2'b01, 4'h0, rows[i].op});
                wr(ADDR_CTRL, 32'h3);
                u_cpu.store_program_memory_instr(15'h7fff, 15'h0);
                @(posedge clk);
                check("busy_clr", rww_block, 1'b0);
            end
            wr(ADDR_STAT, 32'h7);
        end
        wr(ADDR_MASK, 32'h4);
        wr(ADDR_LDATA, 32'h7);
        wr(ADDR_CTRL, 32'h2);
        u_cpu.store_program_memory_instr(15'h7fff, 15'h0);
        rd_chk("lock", ADDR_LOCK, 32'h7);
        u_cpu.lpm(15'h0100, 15'h7d00);
        @(negedge clk);
        check("deny", lpm_deny, 1'b1);
        @(negedge clk);
        check("irq", irq, 1'b1);
        wr(ADDR_STAT, 32'h4);
        repeat (2) @(posedge clk);
        check("irq_clr", irq, 1'b0);
        wr(ADDR_LDATA, 32'he);
        wr(ADDR_CTRL, 32'h2);
        u_cpu.store_program_memory_instr(15'h7fff, 15'h0);
        rd_chk("lock_app", ADDR_LOCK, 32'h6);
        wr(ADDR_CTRL, 32'h1);
        u_cpu.store_program_memory_instr(15'h7fff, 15'h0100);
        @(posedge clk);
        check("locked", fl_start, 1'b0);
        @(posedge clk) chip_erase <= 1'b1;
        @(posedge clk) chip_erase <= 1'b0;
        rd_chk("erased", ADDR_LOCK, 32'hf);
        ext_val <= 4'hd;
        ext_we <= 1'b1;
        @(posedge clk) ext_we <= 1'b0;
        wr(ADDR_LDATA, 32'hf);
        wr(ADDR_CTRL, 32'h2);
        u_cpu.store_program_memory_instr(15'h7fff, 15'h0);
        rd_chk("no_unset", ADDR_LOCK, 32'hd);
        vec_in_boot <= 1'b1;
        u_cpu.lpm(15'h0100, 15'h0100);
        repeat (3) @(posedge clk);
        check("irq_block", irq_block, 1'b1);
        apb(1'b0, 8'h20, 32'h0, d, e);
        check("slverr", e, 1'b1);
        check("unmapped", d, 32'h0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk("lock_rst", ADDR_LOCK, {28'h0, LOCK_RESET});
        rd_chk("ctrl_rst", ADDR_CTRL, 32'h0);
        wrap_up();
    end
endmodule
